// >>> inc/hbf_defs.svh
`ifndef HBF_DEFS_SVH
`define HBF_DEFS_SVH
// frame delimiter, sent and hunted on the link
`define HBF_FLAG       8'h7E
// address byte values marking command or response
`define HBF_ADDR_CMD   8'h03
`define HBF_ADDR_RSP   8'h01
// bit-reversed crc-16 generator, remainder starts at zero
`define HBF_CRC_POLY   16'hA001
// information field ceilings, short and long setting
`define HBF_INFO_SHORT 11'h080
`define HBF_INFO_LONG  11'h400
// run of ones that forces a zero, and run that aborts
`define HBF_STUFF_RUN  3'h5
`define HBF_ABORT_RUN  3'h6
// bits per byte on the serial link, less one
`define HBF_LAST_BIT   3'h7
`endif

// >>> inc/hbf_pkg.sv
package hbf_pkg;
  // transmit serializer state, one hot
  typedef enum logic [5:0] {
    TX_IDLE  = 6'h01,
    TX_ADDR  = 6'h02,
    TX_CTRL  = 6'h04,
    TX_INFO  = 6'h08,
    TX_FCS   = 6'h10,
    TX_CLOSE = 6'h20
  } hbf_tx_st_t;
  // control field format, coded from control bits 1:0
  typedef enum logic [1:0] {
    FMT_INFO  = 2'h0,
    FMT_SUPV  = 2'h1,
    FMT_UNNUM = 2'h3
  } hbf_fmt_t;
endpackage : hbf_pkg

// >>> verilog/hbf_framer.sv
// What this block does
// [R01] flag pattern is 01111110 both ways
// [R02] every frame opens and closes with flag
// [R03] frames follow one another without limit
// [R04] receiver counts fields from opening flag
// [R05] closing flag ends frame, fcs precedes
// [R06] zero inserted after five body ones
// [R07] receiver deletes zero after five ones
// [R08] stuffed zeros kept out of crc
// [R09] receiver hunts flag at every bit
// [R10] idle link carries back-to-back flags
// [R11] address byte marks command or response
// [R12] frames routed to primary or secondary
// [R13] control field is exactly eight bits
// [R14] control decoded into three formats
// [R15] supervisory frames carry no information
// [R16] only information frames carry information
// [R17] information bytes pass through unrestricted
// [R18] information ceiling 128 or 1024 bytes
// [R19] lamp lit while link connected; this block has no lamp output
// [R20] lamp lit during backplane transfer; this block has no lamp output
// [R21] all four lamps off after self-test; this block has no lamps and no self-test
// [R22] crc-16 remainder sent before closing flag
// [R23] flags themselves are never zero-stuffed
`timescale 1ns/10ps
`include "hbf_defs.svh"
module hbf_framer #(
  parameter logic [7:0] LINK_HALF_DIV = 8'h08     // sys clocks per half bit of sent link clock
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             clk_link_rx,      // clock sent with received data
  input  wire logic             link_rx_data,
  output logic                  link_tx_clk,
  output logic                  link_tx_data,
  input  wire logic             cfg_long_info,    // high selects the long ceiling
  input  wire logic             tx_frame_valid,
  output logic                  tx_frame_ready,
  input  wire logic             tx_is_cmd,
  input  wire logic [7:0]       tx_ctrl,
  input  wire logic             tx_byte_valid,
  output logic                  tx_byte_ready,
  input  wire logic [7:0]       tx_byte,
  input  wire logic             tx_byte_last,
  output logic                  rx_hdr_valid,
  output logic                  rx_is_cmd,
  output logic [7:0]            rx_ctrl,
  output hbf_pkg::hbf_fmt_t     rx_fmt,
  output logic                  rx_byte_valid,
  output logic [7:0]            rx_byte,
  output logic                  rx_end,
  output logic                  rx_fcs_ok
);
  // one crc step per data bit, lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c[0] ^ b) ? ({1'b0, c[15:1]} ^ `HBF_CRC_POLY) : {1'b0, c[15:1]};
  endfunction : crc_step

  hbf_pkg::hbf_tx_st_t st_r;            // byte now in the shifter
  logic [7:0]          div_r;           // half-bit divider
  logic [7:0]          sh_r;            // outgoing byte, lsb first
  logic [2:0]          bits_r;          // bits of sh_r already sent
  logic [2:0]          ones_r;          // run of body ones just sent
  logic [15:0]         crc_r;           // running transmit remainder
  logic [7:0]          fcs_hi_r;        // second fcs byte waiting
  logic                fcs2_r;          // second fcs byte in shifter
  logic                fr_pend_r;       // frame accepted, not yet started
  logic [7:0]          fr_addr_r;
  logic [7:0]          fr_ctrl_r;
  logic                info_open_r;     // more information bytes may come
  logic [10:0]         info_cnt_r;
  logic [7:0]          nb_r;            // one-byte lookahead for the shifter
  logic                nb_valid_r;
  logic                bit_tick;        // link clock falls, next bit goes out
  logic                stuff;
  logic                body;
  logic                byte_end;
  logic                take_fr;
  logic                take_b;
  logic                consume;
  logic [15:0]         crc_nxt;
  logic [10:0]         info_max;
  logic                cfg_s1_r;        // ceiling switch, first sync stage
  logic                cfg_s2_r;        // ceiling switch, safe to read

  assign bit_tick = (div_r == LINK_HALF_DIV - 8'h01) && link_tx_clk;
  assign stuff    = (ones_r == `HBF_STUFF_RUN);
  assign body     = (st_r == hbf_pkg::TX_ADDR) || (st_r == hbf_pkg::TX_CTRL) ||
                    (st_r == hbf_pkg::TX_INFO) || (st_r == hbf_pkg::TX_FCS);
  assign byte_end = bit_tick && !stuff && (bits_r == `HBF_LAST_BIT);
  assign take_fr  = tx_frame_valid && tx_frame_ready;
  assign take_b   = tx_byte_valid && tx_byte_ready;
  assign consume  = byte_end && nb_valid_r && ((st_r == hbf_pkg::TX_CTRL) || (st_r == hbf_pkg::TX_INFO));
  assign info_max = cfg_s2_r ? `HBF_INFO_LONG : `HBF_INFO_SHORT;  // R18

  // the ceiling switch is a board pin, so it is brought in through two stages
  always_ff @(posedge clk_sys) begin
    cfg_s1_r <= cfg_long_info;
    cfg_s2_r <= cfg_s1_r;
  end
  // stuffed zeros and fcs bits never reach the remainder
  assign crc_nxt  = (bit_tick && !stuff && body && (st_r != hbf_pkg::TX_FCS)) ? crc_step(crc_r, sh_r[0]) : crc_r;  // R08

  // link clock made by division, so the sending side needs no second domain
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_r       <= 8'h00;
      link_tx_clk <= 1'b1;
    end else if (div_r == LINK_HALF_DIV - 8'h01) begin
      div_r       <= 8'h00;
      link_tx_clk <= ~link_tx_clk;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // serializer: data changes on the falling link edge, far end samples on the rise
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r         <= hbf_pkg::TX_IDLE;
      sh_r         <= `HBF_FLAG;
      bits_r       <= 3'h0;
      ones_r       <= 3'h0;
      fcs_hi_r     <= 8'h00;
      fcs2_r       <= 1'b0;
      link_tx_data <= 1'b1;
    end else if (bit_tick) begin
      if (stuff) begin
        link_tx_data <= 1'b0;           // R06
        ones_r       <= 3'h0;
      end else begin
        link_tx_data <= sh_r[0];
        sh_r         <= {1'b0, sh_r[7:1]};
        bits_r       <= bits_r + 3'h1;
        // flag bits clear the run, so flags go out unstuffed
        ones_r       <= (body && sh_r[0]) ? ones_r + 3'h1 : 3'h0;  // R23
        if (bits_r == `HBF_LAST_BIT) begin
          unique case (st_r)
            hbf_pkg::TX_IDLE: begin
              // the flag just sent is the opening flag
              if (fr_pend_r) begin      // R02
                st_r <= hbf_pkg::TX_ADDR;
                sh_r <= fr_addr_r;
              end else begin
                sh_r <= `HBF_FLAG;      // R10
              end
            end
            hbf_pkg::TX_ADDR: begin
              st_r <= hbf_pkg::TX_CTRL;
              sh_r <= fr_ctrl_r;        // R13
            end
            hbf_pkg::TX_CTRL, hbf_pkg::TX_INFO: begin
              if (nb_valid_r) begin
                st_r <= hbf_pkg::TX_INFO;
                sh_r <= nb_r;
              end else begin
                st_r     <= hbf_pkg::TX_FCS;
                sh_r     <= crc_nxt[7:0];  // R22
                fcs_hi_r <= crc_nxt[15:8];
                fcs2_r   <= 1'b0;
              end
            end
            hbf_pkg::TX_FCS: begin
              if (!fcs2_r) begin
                sh_r   <= fcs_hi_r;
                fcs2_r <= 1'b1;
              end else begin
                st_r <= hbf_pkg::TX_CLOSE;
                sh_r <= `HBF_FLAG;      // R01
              end
            end
            hbf_pkg::TX_CLOSE: begin
              // one more flag always parts two frames
              st_r <= hbf_pkg::TX_IDLE;
              sh_r <= `HBF_FLAG;
            end
          endcase
        end
      end
    end
  end

  // remainder cleared as each frame leaves the opening flag
  always_ff @(posedge clk_sys) begin
    if (reset || (byte_end && (st_r == hbf_pkg::TX_IDLE) && fr_pend_r)) begin
      crc_r <= 16'h0000;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  // frame intake: ready again once the previous frame is out
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fr_pend_r      <= 1'b0;
      fr_addr_r      <= 8'h00;
      fr_ctrl_r      <= 8'h00;
      tx_frame_ready <= 1'b0;
    end else begin
      tx_frame_ready <= !take_fr && !fr_pend_r &&
                        ((st_r == hbf_pkg::TX_IDLE) || (st_r == hbf_pkg::TX_CLOSE));  // R03
      if (take_fr) begin
        fr_pend_r <= 1'b1;
        fr_addr_r <= tx_is_cmd ? `HBF_ADDR_CMD : `HBF_ADDR_RSP;  // R11
        fr_ctrl_r <= tx_ctrl;
      end else if (byte_end && (st_r == hbf_pkg::TX_IDLE)) begin
        fr_pend_r <= 1'b0;
      end
    end
  end

  // information intake; a starved lookahead closes the field early
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      info_open_r   <= 1'b0;
      info_cnt_r    <= 11'h000;
      nb_r          <= 8'h00;
      nb_valid_r    <= 1'b0;
      tx_byte_ready <= 1'b0;
    end else begin
      tx_byte_ready <= info_open_r && !nb_valid_r && !take_b;
      if (take_fr) begin
        info_open_r <= !tx_ctrl[0];     // R16 R15
        info_cnt_r  <= 11'h000;
      end else if (take_b) begin
        info_cnt_r <= info_cnt_r + 11'h001;
        if (tx_byte_last || (info_cnt_r + 11'h001 == info_max)) begin
          info_open_r <= 1'b0;          // R18
        end
      end else if (byte_end && !nb_valid_r && (st_r == hbf_pkg::TX_CTRL || st_r == hbf_pkg::TX_INFO)) begin
        info_open_r <= 1'b0;
      end
      if (take_b) begin
        nb_r       <= tx_byte;
        nb_valid_r <= 1'b1;
      end else if (consume) begin
        nb_valid_r <= 1'b0;
      end
    end
  end

  // ---- receive side, on the clock that arrives with the data ----
  logic        rst_l1_r;                // reset synchroniser, first stage
  logic        rst_l2_r;
  logic [7:0]  win_r;                   // last raw bits, newest on top
  logic [2:0]  rones_r;                 // raw run of ones
  logic        in_frame_r;
  logic [7:0]  rsh_r;
  logic [2:0]  rbits_r;
  logic [2:0]  rcnt_r;                  // bytes of this frame, saturates at 4
  logic [15:0] rcrc_r;
  logic [15:0] rcrc_byte_r;             // remainder at the last byte boundary
  logic [7:0]  d0_r;                    // two-byte hold so fcs is never delivered
  logic [7:0]  d1_r;
  logic        ev_tgl_r;
  logic [9:0]  ev_word_r;               // {end, fcs good, byte}
  logic        rb;
  logic        flag_hit;
  logic        destuff;

  assign rb       = link_rx_data;
  assign flag_hit = ({rb, win_r[7:1]} == `HBF_FLAG);  // R01 R09
  assign destuff  = !rb && (rones_r == `HBF_STUFF_RUN);  // R07

  always_ff @(posedge clk_link_rx) begin
    rst_l1_r <= reset;
    rst_l2_r <= rst_l1_r;
  end

  // flag hunt on every bit, destuffing and byte assembly
  always_ff @(posedge clk_link_rx) begin
    if (rst_l2_r) begin
      win_r       <= 8'h00;
      rones_r     <= 3'h0;
      in_frame_r  <= 1'b0;
      rsh_r       <= 8'h00;
      rbits_r     <= 3'h0;
      rcnt_r      <= 3'h0;
      rcrc_r      <= 16'h0000;
      rcrc_byte_r <= 16'h0000;
      d0_r        <= 8'h00;
      d1_r        <= 8'h00;
      ev_tgl_r    <= 1'b0;
      ev_word_r   <= 10'h000;
    end else begin
      win_r   <= {rb, win_r[7:1]};
      rones_r <= !rb ? 3'h0 : (rones_r == 3'h7) ? 3'h7 : rones_r + 3'h1;
      if (flag_hit) begin
        // partial flag bits in the shifter are dropped with the boundary
        if (rcnt_r >= 3'h3) begin       // R05
          ev_tgl_r  <= ~ev_tgl_r;
          ev_word_r <= {1'b1, in_frame_r && (rcnt_r == 3'h4) && (rbits_r == `HBF_LAST_BIT) &&
                        (rcrc_byte_r == 16'h0000), 8'h00};
        end
        in_frame_r  <= 1'b1;
        rbits_r     <= 3'h0;
        rcnt_r      <= 3'h0;
        rcrc_r      <= 16'h0000;
        rcrc_byte_r <= 16'h0000;
      end else if (rb && (rones_r == `HBF_ABORT_RUN)) begin
        in_frame_r <= 1'b0;             // seven ones: frame abandoned
      end else if (in_frame_r && !destuff) begin
        rsh_r   <= {rb, rsh_r[7:1]};
        rbits_r <= rbits_r + 3'h1;
        rcrc_r  <= crc_step(rcrc_r, rb);  // R08
        if (rbits_r == `HBF_LAST_BIT) begin
          rcrc_byte_r <= crc_step(rcrc_r, rb);
          d0_r        <= {rb, rsh_r[7:1]};
          d1_r        <= d0_r;
          rcnt_r      <= (rcnt_r == 3'h4) ? 3'h4 : rcnt_r + 3'h1;  // R04
          if (rcnt_r >= 3'h2) begin
            ev_tgl_r  <= ~ev_tgl_r;
            ev_word_r <= {2'h0, d1_r};
          end
        end
      end
    end
  end

  // ---- events into the system domain: toggle sync, word held for a byte time ----
  logic       ev_s1_r;
  logic       ev_s2_r;
  logic       ev_s3_r;
  logic [1:0] ridx_r;                   // 0 address, 1 control, 2 information
  logic       ev_edge;

  assign ev_edge = ev_s2_r ^ ev_s3_r;

  always_ff @(posedge clk_sys) begin
    ev_s1_r <= ev_tgl_r;
    ev_s2_r <= ev_s1_r;
    ev_s3_r <= ev_s2_r;
  end

  // field split of delivered bytes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ridx_r        <= 2'h0;
      rx_hdr_valid  <= 1'b0;
      rx_is_cmd     <= 1'b0;
      rx_ctrl       <= 8'h00;
      rx_fmt        <= hbf_pkg::FMT_INFO;
      rx_byte_valid <= 1'b0;
      rx_byte       <= 8'h00;
      rx_end        <= 1'b0;
      rx_fcs_ok     <= 1'b0;
    end else begin
      rx_hdr_valid  <= 1'b0;
      rx_byte_valid <= 1'b0;
      rx_end        <= 1'b0;
      if (ev_edge) begin
        if (ev_word_r[9]) begin
          rx_end    <= 1'b1;
          rx_fcs_ok <= ev_word_r[8];
          ridx_r    <= 2'h0;
        end else if (ridx_r == 2'h0) begin
          rx_is_cmd <= (ev_word_r[7:0] == `HBF_ADDR_CMD);  // R11 R12
          ridx_r    <= 2'h1;
        end else if (ridx_r == 2'h1) begin
          rx_ctrl      <= ev_word_r[7:0];
          rx_fmt       <= hbf_pkg::hbf_fmt_t'(ev_word_r[0] ? {ev_word_r[1], 1'b1} : 2'h0);  // R14
          rx_hdr_valid <= 1'b1;
          ridx_r       <= 2'h2;
        end else begin
          rx_byte       <= ev_word_r[7:0];  // R17
          rx_byte_valid <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_fcs_enter;
    byte_end && !nb_valid_r && (st_r == hbf_pkg::TX_CTRL || st_r == hbf_pkg::TX_INFO);
  endsequence
  sequence s_fcs_leave;
    (st_r == hbf_pkg::TX_FCS) ##1 (st_r != hbf_pkg::TX_FCS);
  endsequence

  property p_stuff; bit_tick && stuff |=> !link_tx_data && ones_r == 3'h0; endproperty
  a_stuff: assert property (p_stuff) else $error("no zero after five ones");  // R06
  property p_crc_hold; bit_tick && stuff |=> $stable(crc_r); endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("stuffed zero entered crc");  // R08
  property p_flag_no_run; (st_r == hbf_pkg::TX_IDLE) && bit_tick && !stuff |=> ones_r == 3'h0; endproperty
  a_flag_no_run: assert property (p_flag_no_run) else $error("flag bits counted for stuffing");  // R23
  property p_idle; byte_end && st_r == hbf_pkg::TX_CLOSE |=> st_r == hbf_pkg::TX_IDLE && sh_r == `HBF_FLAG; endproperty
  a_idle: assert property (p_idle) else $error("idle flag missing");  // R10
  property p_open; $rose(st_r == hbf_pkg::TX_ADDR) |-> $past(st_r) == hbf_pkg::TX_IDLE; endproperty
  a_open: assert property (p_open) else $error("frame without opening flag");  // R02
  property p_fcs; s_fcs_enter |=> st_r == hbf_pkg::TX_FCS && sh_r == $past(crc_nxt[7:0]); endproperty
  a_fcs: assert property (p_fcs) else $error("fcs low byte wrong");  // R22
  property p_close; s_fcs_leave |-> st_r == hbf_pkg::TX_CLOSE && sh_r == `HBF_FLAG; endproperty
  a_close: assert property (p_close) else $error("no closing flag after fcs");  // R01
  property p_addr; byte_end && st_r == hbf_pkg::TX_IDLE && fr_pend_r |=> sh_r == fr_addr_r; endproperty
  a_addr: assert property (p_addr) else $error("address byte not sent");  // R11
  property p_no_info; byte_end && st_r == hbf_pkg::TX_CTRL && fr_ctrl_r[0] |=> st_r == hbf_pkg::TX_FCS; endproperty
  a_no_info: assert property (p_no_info) else $error("non-information frame got bytes");  // R16
  property p_info_max; info_cnt_r <= info_max; endproperty
  a_info_max: assert property (p_info_max) else $error("information ceiling passed");  // R18
  property p_again; st_r == hbf_pkg::TX_IDLE && !fr_pend_r && !tx_frame_valid |=> tx_frame_ready; endproperty
  a_again: assert property (p_again) else $error("next frame not accepted");  // R03
endmodule : hbf_framer

// >>> sim/hbf_far_end.sv
`timescale 1ns/10ps
`include "hbf_defs.svh"
// model of the remote card: sends framed traffic and captures what the block sends
module hbf_far_end (
  input  wire logic link_tx_clk,   // clock arriving with the block's data
  input  wire logic link_tx_data,  // block's data, sampled on the rise
  output logic      clk_link_rx,   // our clock; flags never stop, so it runs free
  output logic      link_rx_data   // our data, changed on the fall
);
  bit         tx_bits[$];          // stuffed bits waiting for the wire
  int         run = 0;             // ones in a row in the body
  logic [7:0] rx_bytes[$];         // destuffed bytes of captured frames
  int         rx_lens[$];          // length of each captured frame
  int         n_flags = 0;         // flags seen from the block
  logic [7:0] cur[$];              // frame being gathered
  logic [7:0] raw_r = 8'h00;       // last eight raw bits
  logic [7:0] acc_r = 8'h00;       // byte in progress, destuffed
  int         ones = 0;            // raw ones in a row
  int         nbit = 0;            // bits in acc_r

  // reflected crc-16, one byte lsb first
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ `HBF_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16

  // one byte lsb first; only body bytes are stuffed
  task automatic put(input logic [7:0] b, input bit body);
    for (int i = 0; i < 8; i++) begin
      tx_bits.push_back(b[i]);
      run = (body && b[i]) ? run + 1 : 0;
      if (run == 5) begin
        tx_bits.push_back(1'b0);
        run = 0;
      end
    end
  endtask : put

  // queued whole, so an idle flag can never split a frame; bad spoils the check
  task automatic send_frame(input logic [7:0] fb[$], input bit bad);
    logic [15:0] c;
    c = 16'h0000;
    put(`HBF_FLAG, 1'b0);
    foreach (fb[i]) begin
      put(fb[i], 1'b1);
      c = crc16(c, fb[i]);
    end
    c[0] = c[0] ^ bad;
    put(c[7:0], 1'b1);
    put(c[15:8], 1'b1);
    put(`HBF_FLAG, 1'b0);
  endtask : send_frame

  // link clock, phase unrelated to the system clock
  initial begin
    clk_link_rx = 1'b1;
    link_rx_data = 1'b1;
    #13;
    forever #40 clk_link_rx = ~clk_link_rx;
  end

  // drive on the fall; an empty queue refills with flags
  always @(negedge clk_link_rx) begin
    if (tx_bits.size() == 0) put(`HBF_FLAG, 1'b0);
    link_rx_data <= tx_bits.pop_front();
  end

  // capture: hunt at every bit, drop stuffed zeros, keep frames of four bytes or more
  always @(posedge link_tx_clk) begin
    raw_r = {link_tx_data, raw_r[7:1]};
    if (raw_r == `HBF_FLAG) begin
      n_flags++;
      if (cur.size() >= 4) begin
        rx_lens.push_back(cur.size());
        foreach (cur[i]) rx_bytes.push_back(cur[i]);
      end
      cur.delete();
      nbit = 0;
      ones = 0;
    end else if (ones == 5 && link_tx_data == 1'b0) begin
      ones = 0;
    end else begin
      acc_r = {link_tx_data, acc_r[7:1]};
      ones = link_tx_data ? ones + 1 : 0;
      nbit++;
      if (nbit == 8) begin
        cur.push_back(acc_r);
        nbit = 0;
      end
    end
  end
endmodule : hbf_far_end

// >>> sim/tb_hdlc_bit_framer.sv
`timescale 1ns/10ps
`include "hbf_defs.svh"
module tb_hdlc_bit_framer;
  logic              clk_sys, reset, clk_link_rx, link_rx_data, link_tx_clk, link_tx_data;
  logic              cfg_long_info, tx_frame_valid, tx_frame_ready, tx_is_cmd, tx_byte_valid;
  logic              tx_byte_ready, tx_byte_last, rx_hdr_valid, rx_is_cmd, rx_byte_valid, rx_end, rx_fcs_ok;
  logic [7:0]        tx_ctrl, tx_byte, rx_ctrl, rx_byte;
  hbf_pkg::hbf_fmt_t rx_fmt;
  int                n_errors = 0, n_compared = 0, n_cyc = 0, n_ends = 0, f0;
  logic [8:0]        hdr_q[$];  // expected command bit and control byte
  logic [7:0]        rxb_q[$];  // expected delivered information bytes
  bit                ok_q[$];   // expected check result per frame
  logic [7:0]        codes[9] = '{8'h10, 8'h01, 8'h05, 8'h09, 8'h0F, 8'h43, 8'h63, 8'h87, 8'h07};

  // short link bit keeps the long frame within the run
  hbf_framer #(.LINK_HALF_DIV(8'h02)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .clk_link_rx(clk_link_rx), .link_rx_data(link_rx_data),
    .link_tx_clk(link_tx_clk), .link_tx_data(link_tx_data), .cfg_long_info(cfg_long_info),
    .tx_frame_valid(tx_frame_valid), .tx_frame_ready(tx_frame_ready), .tx_is_cmd(tx_is_cmd),
    .tx_ctrl(tx_ctrl), .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready), .tx_byte(tx_byte),
    .tx_byte_last(tx_byte_last), .rx_hdr_valid(rx_hdr_valid), .rx_is_cmd(rx_is_cmd), .rx_ctrl(rx_ctrl),
    .rx_fmt(rx_fmt), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_end(rx_end),
    .rx_fcs_ok(rx_fcs_ok));
  hbf_far_end far_u (.link_tx_clk(link_tx_clk), .link_tx_data(link_tx_data),
    .clk_link_rx(clk_link_rx), .link_rx_data(link_rx_data));

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // hang guard, well above the expected run
  always @(posedge clk_sys) begin
    n_cyc++;
    if (n_cyc == 90000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk_link(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t link got %h exp %h", $time, got, exp);
    end
  endtask : chk_link

  task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t port got %h exp %h", $time, got, exp);
    end
  endtask : chk_port

  // inputs always move one step after the rising edge
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  // send one frame; bytes are offered to other formats too, which must refuse them
  task automatic tx_frame(input bit cmd, input logic [7:0] ctrl, input int n);
    logic [7:0]  q[$];
    logic [15:0] c;
    int          k;
    k = cfg_long_info ? `HBF_INFO_LONG : `HBF_INFO_SHORT;
    k = ctrl[0] ? 0 : (n < k ? n : k);
    tx_is_cmd = cmd;
    tx_ctrl = ctrl;
    tx_frame_valid = 1'b1;
    tx_byte_valid = ctrl[0];
    q.push_back(cmd ? `HBF_ADDR_CMD : `HBF_ADDR_RSP);
    q.push_back(ctrl);
    while (tx_frame_ready !== 1'b1) tick();
    tick();
    tx_frame_valid = 1'b0;
    for (int i = 0; i < k; i++) begin
      tx_byte = (i % 3 == 0) ? 8'hFF : 8'($urandom);  // ones runs force stuffing
      tx_byte_last = (i == n - 1);
      tx_byte_valid = 1'b1;
      q.push_back(tx_byte);
      while (tx_byte_ready !== 1'b1) tick();
      tick();
    end
    tx_byte_valid = ctrl[0];
    c = 16'h0000;
    foreach (q[i]) c = far_u.crc16(c, q[i]);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    while (far_u.rx_lens.size() == 0) tick();
    tx_byte_valid = 1'b0;
    chk_link(16'(far_u.rx_lens.pop_front()), 16'(q.size()));
    foreach (q[i]) chk_link({8'h00, far_u.rx_bytes.pop_front()}, {8'h00, q[i]});
  endtask : tx_frame

  // queue a frame at the far end and note what the block must report
  task automatic rx_frame(input bit cmd, input logic [7:0] ctrl, input int n, input bit bad);
    logic [7:0] q[$];
    q.push_back(cmd ? `HBF_ADDR_CMD : `HBF_ADDR_RSP);
    q.push_back(ctrl);
    hdr_q.push_back({cmd, ctrl});
    ok_q.push_back(!bad);
    for (int i = 0; i < n; i++) begin
      q.push_back(i[0] ? `HBF_FLAG : 8'($urandom));  // flag-valued data must pass
      rxb_q.push_back(q[i + 2]);
    end
    far_u.send_frame(q, bad);
  endtask : rx_frame

  // receive-side monitor against the expected queues
  always @(posedge clk_sys) begin
    if (reset === 1'b0) begin
      if (rx_hdr_valid === 1'b1) begin
        chk_port({7'h00, rx_is_cmd, rx_ctrl}, {7'h00, hdr_q[0]});
        chk_port({14'h0000, rx_fmt}, {14'h0000, hdr_q[0][0] ? hdr_q[0][1:0] : 2'h0});
        void'(hdr_q.pop_front());
      end
      if (rx_byte_valid === 1'b1) chk_port({8'h00, rx_byte}, {8'h00, rxb_q.pop_front()});
      if (rx_end === 1'b1) begin
        chk_port({15'h0000, rx_fcs_ok}, {15'h0000, ok_q.pop_front()});
        n_ends++;
      end
    end
  end

  initial begin
    reset = 1'b1;
    cfg_long_info = 1'b0;
    tx_frame_valid = 1'b0;
    tx_is_cmd = 1'b0;
    tx_ctrl = 8'h00;
    tx_byte_valid = 1'b0;
    tx_byte = 8'h00;
    tx_byte_last = 1'b0;
    void'($urandom(32'h3e5ba1a9));
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    f0 = far_u.n_flags;
    repeat (400) tick();
    chk_link(16'(far_u.n_flags - f0 >= 10), 16'h0001);
    chk_link(16'(far_u.rx_lens.size()), 16'h0000);
    // every format both ways at once; received frames come back to back
    foreach (codes[i]) begin
      fork
        tx_frame(i[0], codes[i], 6);
        begin
          rx_frame(!i[0], codes[i], codes[i][0] ? 0 : 6, i == 3);
          rx_frame(i[0], codes[i], codes[i][0] ? 0 : 3, 1'b0);
        end
      join
    end
    while (n_ends < 18) tick();
    tx_frame(1'b1, 8'h00, 130);
    cfg_long_info = 1'b1;
    tx_frame(1'b0, 8'h32, 1030);
    repeat (50) tick();
    chk_port(16'(hdr_q.size() + rxb_q.size() + ok_q.size()), 16'h0000);
    stop_test();
  end
endmodule : tb_hdlc_bit_framer
